/* src/pwmt_pkg.sv */
/*
 * Package of the match timer / pulse width modulator: register byte
 * offsets, field positions, reset values and the bus request carrier.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package pwmt_pkg;

	localparam int PWMT_DW = 32;
	localparam int PWMT_AW = 6;
	localparam int PWMT_NMATCH = 7;
	localparam int PWMT_NOUT = 6;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [PWMT_AW-1:0] PWMT_OFS_CTRL = 6'h00;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_COUNT = 6'h04;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_PRESCALE = 6'h08;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_PRECOUNT = 6'h0C;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_MATCHCTL = 6'h10;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_OUTCTL = 6'h14;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_RELEASE = 6'h18;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_FLAGS = 6'h1C;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_MATCH0 = 6'h20;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_MATCH6 = 6'h38;
	localparam logic [PWMT_AW-1:0] PWMT_OFS_PINS = 6'h3C;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int PWMT_CTRL_RUN = 0;
	localparam int PWMT_CTRL_HOLD = 1;
	localparam int PWMT_CTRL_PWM = 3;
	localparam int PWMT_MCTL_IRQ = 0;
	localparam int PWMT_MCTL_RST = 1;
	localparam int PWMT_MCTL_STOP = 2;
	localparam int PWMT_MCTL_STRIDE = 3;
	localparam int PWMT_OCTL_DBL = 0;
	localparam int PWMT_OCTL_EN = 8;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [3:0] PWMT_CTRL_RST = 4'h0;
	localparam logic [PWMT_DW-1:0] PWMT_WORD_RST = 32'h00000000;
	localparam logic [PWMT_NMATCH-1:0] PWMT_BITS_RST = 7'h00;
	localparam logic [PWMT_DW-1:0] PWMT_MATCH_RST = 32'h00000000;

	typedef struct packed {
		logic read;
		logic write;
		logic [PWMT_AW-1:0] address;
		logic [PWMT_DW-1:0] writedata;
	} pwmt_avreq_type;

	typedef struct packed {
		logic waitrequest;
		logic [PWMT_DW-1:0] readdata;
	} pwmt_avrsp_type;

endpackage : pwmt_pkg

/* src/pwmt_prescale.sv */
/*
 * Prescaler of the match timer: counts clock cycles up to a limit and
 * gives a one-cycle tick on the wrap. Assumes synchronous reset.
 */
`timescale 1ns/1ps
module pwmt_prescale #(
	parameter int WIDTH = 32
) (
	input wire logic clk, // Core clock
	input wire logic rst, // Synchronous reset
	input wire logic run, // Count enable
	input wire logic clr, // Hold at zero
	input wire logic [WIDTH-1:0] limit, // Ticks every limit+1 cycles
	input wire logic wr_en, // Software load
	input wire logic [WIDTH-1:0] wr_data, // Load value
	output logic tick, // One-cycle timer advance
	output logic [WIDTH-1:0] count // Current count
);
	logic [WIDTH-1:0] count_ff;

	assign count = count_ff;
	assign tick = run && !clr && (count_ff == limit);

	always_ff @(posedge clk) begin
		if (rst || clr) begin
			count_ff <= '0;
		end else if (wr_en) begin
			count_ff <= wr_data;
		end else if (run) begin
			count_ff <= (count_ff == limit) ? '0 : count_ff + 1'b1;
		end
	end

endmodule : pwmt_prescale

/* src/pwmt_top.sv */
/*
 * Match timer with pulse width modulation: 32-bit counter behind a
 * 32-bit prescaler, seven match registers, six modulated outputs,
 * Avalon-MM register slave with one wait state.
 * Assumes one 10 MHz clock, synchronous active-high reset, inputs
 * synchronous to the clock.
 */
// The address map and register access over Avalon-MM are this design's own decisions.
// Behaviour
// - The counter advances on prescaled clock cycles and is compared with seven match values.
// - Counter and prescaler are both 32 bits wide and the prescale limit is written by software.
// - A cycle match resets the count and sets the period of every output.
// - A single-edge output has its falling edge placed by one further match register.
// - Single-edge outputs go high at each cycle start unless programmed constant low.
// - A double-edge output takes its rising and falling positions from two match registers.
// - Rising before falling gives a positive pulse, falling before rising a negative one.
// - The seven matches serve six single-edge, three double-edge outputs or any mix.
// - Each match may continue, stop or reset the counter, each with an optional flag.
// - Period and width are any whole number of timer counts.
// - All outputs share one repetition rate.
// - In modulation mode a written match value waits for software release and then applies in step with outputs.
// - With modulation off the block is a plain match timer.
`timescale 1ns/1ps
module pwmt_top
	import pwmt_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int PRE_W = 32
) (
	input wire logic CORE_CLK, // 10 MHz clock
	input wire logic SYS_RST, // Synchronous reset, active high
	input wire pwmt_pkg::pwmt_avreq_type AVS_REQ, // Avalon request
	output pwmt_pkg::pwmt_avrsp_type AVS_RSP, // Avalon answer
	output logic [pwmt_pkg::PWMT_NOUT-1:0] PWM_OUT, // Outputs 1..6
	output logic [pwmt_pkg::PWMT_NMATCH-1:0] MATCH_FLAGS // Sticky flags
);
	import pwmt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	logic [3:0] ctrl_ff;
	logic [CNT_W-1:0] count_ff;
	logic [PRE_W-1:0] prescale_ff;
	logic [PWMT_MCTL_STRIDE*PWMT_NMATCH-1:0] mctl_ff;
	logic [PWMT_OCTL_EN+PWMT_NOUT:0] octl_ff;
	logic [PWMT_NMATCH-1:0] release_ff;
	logic [PWMT_NMATCH-1:0] flags_ff;
	logic [CNT_W-1:0] shadow_ff [PWMT_NMATCH];
	logic [CNT_W-1:0] active_ff [PWMT_NMATCH];
	logic [PWMT_NOUT-1:0] wave_ff;
	logic [PWMT_NOUT-1:0] pin_ff;
	logic ack_ff;
	logic wait_ff;
	logic [PWMT_DW-1:0] rdata_ff;

	logic tick;
	logic [PRE_W-1:0] pre_count;
	logic [PWMT_NMATCH-1:0] hit;
	logic [PWMT_NMATCH-1:0] hit_rst;
	logic [PWMT_NMATCH-1:0] hit_stop;
	logic [PWMT_NMATCH-1:0] hit_irq;
	logic cycle_end;
	logic pwm_mode;
	logic run;
	logic hold;
	logic wr_go;
	logic [PWMT_DW-1:0] nxt_rdata;
	logic [PWMT_NOUT-1:0] nxt_wave;
	logic match_wr;
	logic [2:0] match_idx;

	assign pwm_mode = ctrl_ff[PWMT_CTRL_PWM];
	assign run = ctrl_ff[PWMT_CTRL_RUN];
	assign hold = ctrl_ff[PWMT_CTRL_HOLD];
	// A write lands only at the edge where the master sees waitrequest low
	assign wr_go = AVS_REQ.write && ack_ff;
	assign match_wr = wr_go && (AVS_REQ.address >= PWMT_OFS_MATCH0)
		&& (AVS_REQ.address <= PWMT_OFS_MATCH6) && (AVS_REQ.address[1:0] == 2'b00);
	assign match_idx = 3'(AVS_REQ.address[4:2]);

	////////////////////////////////////////////////////////////////////////
	// Prescaler
	pwmt_prescale #(
		.WIDTH(PRE_W)
	) u_prescale (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.run(run),
		.clr(hold),
		.limit(prescale_ff),
		.wr_en(1'b0),
		.wr_data('0),
		.tick(tick),
		.count(pre_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Match detection, one comparator per match register
	genvar gm;
	generate
		for (gm = 0; gm < PWMT_NMATCH; gm++) begin : g_match
			assign hit[gm] = tick && (count_ff == active_ff[gm]);
			// In modulation mode the cycle match always resets the count
			assign hit_rst[gm] = hit[gm] && (mctl_ff[gm*PWMT_MCTL_STRIDE+PWMT_MCTL_RST]
				|| (gm == 0 && pwm_mode));
			assign hit_stop[gm] = hit[gm]
				&& mctl_ff[gm*PWMT_MCTL_STRIDE+PWMT_MCTL_STOP];
			assign hit_irq[gm] = hit[gm]
				&& mctl_ff[gm*PWMT_MCTL_STRIDE+PWMT_MCTL_IRQ];
		end
	endgenerate

	assign cycle_end = hit_rst[0];

	////////////////////////////////////////////////////////////////////////
	// Control: run, hold and mode; a stop match clears run
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ctrl_ff <= PWMT_CTRL_RST;
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_CTRL) begin
			ctrl_ff <= AVS_REQ.writedata[3:0];
		end else if (|hit_stop) begin
			ctrl_ff[PWMT_CTRL_RUN] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer count
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || hold) begin
			count_ff <= '0;
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_COUNT) begin
			count_ff <= AVS_REQ.writedata[CNT_W-1:0];
		end else if (tick) begin
			if (|hit_rst) begin
				count_ff <= '0;
			end else if (!(|hit_stop)) begin
				count_ff <= count_ff + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			prescale_ff <= PWMT_WORD_RST[PRE_W-1:0];
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_PRESCALE) begin
			prescale_ff <= AVS_REQ.writedata[PRE_W-1:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			mctl_ff <= '0;
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_MATCHCTL) begin
			mctl_ff <= AVS_REQ.writedata[PWMT_MCTL_STRIDE*PWMT_NMATCH-1:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			octl_ff <= '0;
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_OUTCTL) begin
			octl_ff <= AVS_REQ.writedata[PWMT_OCTL_EN+PWMT_NOUT:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky match flags; write one to clear, a new match wins
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			flags_ff <= PWMT_BITS_RST;
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_FLAGS) begin
			flags_ff <= (flags_ff & ~AVS_REQ.writedata[PWMT_NMATCH-1:0]) | hit_irq;
		end else begin
			flags_ff <= flags_ff | hit_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Release bits: set by software, cleared when the value is applied.
	// A release written in the boundary cycle stays armed for the next one.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			release_ff <= PWMT_BITS_RST;
		end else if (wr_go && AVS_REQ.address == PWMT_OFS_RELEASE) begin
			release_ff <= (cycle_end && pwm_mode ? '0 : release_ff)
				| AVS_REQ.writedata[PWMT_NMATCH-1:0];
		end else if (cycle_end && pwm_mode) begin
			release_ff <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Match registers: shadow written by software, active used by compare
	genvar gs;
	generate
		for (gs = 0; gs < PWMT_NMATCH; gs++) begin : g_shadow
			always_ff @(posedge CORE_CLK) begin
				if (SYS_RST) begin
					shadow_ff[gs] <= PWMT_MATCH_RST[CNT_W-1:0];
				end else if (match_wr && match_idx == 3'(gs)) begin
					shadow_ff[gs] <= AVS_REQ.writedata[CNT_W-1:0];
				end
			end

			always_ff @(posedge CORE_CLK) begin
				if (SYS_RST) begin
					active_ff[gs] <= PWMT_MATCH_RST[CNT_W-1:0];
				end else if (!pwm_mode) begin
					active_ff[gs] <= shadow_ff[gs];
				end else if (cycle_end && release_ff[gs]) begin
					// All released values switch on the same boundary
					active_ff[gs] <= shadow_ff[gs];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Output waveforms, channel k uses match k; double edge also k-1
	genvar gc;
	generate
		for (gc = 1; gc <= PWMT_NOUT; gc++) begin : g_chan
			logic dbl;
			logic set_ev;
			logic clr_ev;
			logic low_const;
			// Channel 1 has no spare match below it, so it is single edge only
			assign dbl = (gc > 1) && octl_ff[PWMT_OCTL_DBL+gc];
			assign set_ev = dbl ? hit[gc-1] : cycle_end;
			assign clr_ev = hit[gc];
			// A zero edge position holds a single-edge output low
			assign low_const = !dbl && (active_ff[gc] == '0);
			always_comb begin
				if (low_const) begin
					nxt_wave[gc-1] = 1'b0;
				end else if (dbl) begin
					// Order of the two matches decides the pulse polarity
					nxt_wave[gc-1] = clr_ev ? 1'b0 : (set_ev ? 1'b1 : wave_ff[gc-1]);
				end else begin
					// Edge at the period end: set wins, giving full duty
					nxt_wave[gc-1] = set_ev ? 1'b1 : (clr_ev ? 1'b0 : wave_ff[gc-1]);
				end
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || !pwm_mode) begin
			wave_ff <= '0;
		end else begin
			wave_ff <= nxt_wave;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			pin_ff <= '0;
		end else begin
			pin_ff <= pwm_mode ? (nxt_wave & octl_ff[PWMT_OCTL_EN+PWMT_NOUT:PWMT_OCTL_EN+1])
				: '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets read zero
	always_comb begin
		nxt_rdata = '0;
		unique case (AVS_REQ.address)
			PWMT_OFS_CTRL: nxt_rdata[3:0] = ctrl_ff;
			PWMT_OFS_COUNT: nxt_rdata[CNT_W-1:0] = count_ff;
			PWMT_OFS_PRESCALE: nxt_rdata[PRE_W-1:0] = prescale_ff;
			PWMT_OFS_PRECOUNT: nxt_rdata[PRE_W-1:0] = pre_count;
			PWMT_OFS_MATCHCTL: nxt_rdata[PWMT_MCTL_STRIDE*PWMT_NMATCH-1:0] = mctl_ff;
			PWMT_OFS_OUTCTL: nxt_rdata[PWMT_OCTL_EN+PWMT_NOUT:0] = octl_ff;
			PWMT_OFS_RELEASE: nxt_rdata[PWMT_NMATCH-1:0] = release_ff;
			PWMT_OFS_FLAGS: nxt_rdata[PWMT_NMATCH-1:0] = flags_ff;
			PWMT_OFS_PINS: nxt_rdata[PWMT_NOUT-1:0] = pin_ff;
			default: begin
				if (AVS_REQ.address >= PWMT_OFS_MATCH0 && AVS_REQ.address <= PWMT_OFS_MATCH6
					&& AVS_REQ.address[1:0] == 2'b00) begin
					nxt_rdata[CNT_W-1:0] = shadow_ff[match_idx];
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon handshake: one wait state, then a single ready cycle
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ack_ff <= 1'b0;
			wait_ff <= 1'b1;
		end else begin
			ack_ff <= (AVS_REQ.read || AVS_REQ.write) && !ack_ff;
			wait_ff <= !((AVS_REQ.read || AVS_REQ.write) && !ack_ff);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rdata_ff <= PWMT_WORD_RST;
		end else if (AVS_REQ.read && !ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign AVS_RSP.waitrequest = wait_ff;
	assign AVS_RSP.readdata = rdata_ff;
	assign PWM_OUT = pin_ff;
	assign MATCH_FLAGS = flags_ff;

endmodule : pwmt_top

/* test/pwmt_props.sv */
/*
 * Checker of the match timer: bus handshake, sticky match flags and reset
 * levels, seen only at the ports of the top module.
 * Assumes it is bound to pwmt_top and that reset is synchronous.
 */
`timescale 1ns/1ps
module pwmt_props
	import pwmt_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int PRE_W = 32
) (
	input wire logic CORE_CLK, // Clock
	input wire logic SYS_RST, // Reset
	input wire pwmt_pkg::pwmt_avreq_type AVS_REQ, // Bus request
	input wire pwmt_pkg::pwmt_avrsp_type AVS_RSP, // Bus answer
	input wire logic [pwmt_pkg::PWMT_NOUT-1:0] PWM_OUT, // Outputs
	input wire logic [pwmt_pkg::PWMT_NMATCH-1:0] MATCH_FLAGS // Flags
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////
	sequence take_s;
		(AVS_REQ.read || AVS_REQ.write) && AVS_RSP.waitrequest;
	endsequence
	sequence done_s;
		!AVS_RSP.waitrequest ##1 AVS_RSP.waitrequest;
	endsequence
	// A one-edge reset would leave stale flags in $past, hence the guard
	sequence drop_s;
		!$past(SYS_RST) && |($past(MATCH_FLAGS) & ~MATCH_FLAGS);
	endsequence
	////////////////////////////////////////
	rst_values_a: assert property ($past(SYS_RST) |-> PWM_OUT == '0
		&& MATCH_FLAGS == '0 && AVS_RSP.waitrequest)
		else $error("outputs not at reset levels");
	ack_once_a: assert property (!AVS_RSP.waitrequest |=> AVS_RSP.waitrequest)
		else $error("waitrequest low for more than one cycle");
	ack_cause_a: assert property (!AVS_RSP.waitrequest |->
		$past(AVS_REQ.read) || $past(AVS_REQ.write))
		else $error("answer without a request");
	ack_bound_a: assert property (take_s |-> ##[1:2] done_s)
		else $error("request not answered in time");
	idle_high_a: assert property (!AVS_REQ.read && !AVS_REQ.write
		&& AVS_RSP.waitrequest |=> AVS_RSP.waitrequest)
		else $error("answer while idle");
	read_stable_a: assert property (!$past(SYS_RST) && $changed(AVS_RSP.readdata)
		|-> $past(AVS_REQ.read))
		else $error("read data moved without a read");
	flag_clear_a: assert property (drop_s |-> $past(AVS_REQ.write)
		&& !$past(AVS_RSP.waitrequest) && $past(AVS_REQ.address) == PWMT_OFS_FLAGS)
		else $error("flag dropped without a clearing write");
	flag_mask_a: assert property (drop_s |-> ($past(MATCH_FLAGS) & ~MATCH_FLAGS
		& ~$past(AVS_REQ.writedata[6:0])) == '0)
		else $error("flag dropped that was not written");
endmodule : pwmt_props

/* test/tb_pwm_match_timer.sv */
/*
 * Self-checking bench of the match timer: registers, stop and reset on
 * match, pulse widths, match release, prescaling and a mid-run reset.
 * Assumes the package and the checker are compiled before it.
 */
`timescale 1ns/1ps
module tb_pwm_match_timer;
	import pwmt_pkg::*;
	logic core_clk;
	logic sys_rst;
	pwmt_avreq_type avs_req;
	pwmt_avrsp_type avs_rsp;
	logic [PWMT_NOUT-1:0] pwm_out;
	logic [PWMT_NMATCH-1:0] match_flags;
	int n_mismatch = 0;
	int cmp_count = 0;
	int seed;
	int nv;
	int m [7];
	logic [6:0] dbl;
	logic [31:0] rd;
	pwmt_top u_pwmt_top (
		.CORE_CLK(core_clk),
		.SYS_RST(sys_rst),
		.AVS_REQ(avs_req),
		.AVS_RSP(avs_rsp),
		.PWM_OUT(pwm_out),
		.MATCH_FLAGS(match_flags)
	);
	always #50 core_clk = ~core_clk;
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
		int n = 0;
		@(posedge core_clk);
		avs_req <= '{read: !wr, write: wr, address: adr, writedata: wd};
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
		rd = avs_rsp.readdata;
		avs_req <= '0;
		if (n >= 50) check("bus answer", 32'h0, 32'h1);
	endtask : bus
	task automatic wr(input logic [5:0] adr, input logic [31:0] wd);
		bus(1'b1, adr, wd);
	endtask : wr
	task automatic rdc(input string what, input logic [5:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		check(what, rd, exp);
	endtask : rdc
	// High timer counts per period of output k, from the active match values
	function automatic int exp_hi(input int k);
		int p = m[0] + 1;
		if (dbl[k]) return (m[k-1] < m[k]) ? m[k] - m[k-1] : p - (m[k-1] - m[k]);
		if (m[k] == 0) return 0;
		if (m[k] >= m[0]) return p;
		return m[k] + 1;
	endfunction : exp_hi
	// Counts over whole periods, so the phase of the window does not matter
	task automatic measure(input int per, input int pre);
		int hi [6] = '{default: 0};
		repeat ((m[0] + 1) * pre) @(posedge core_clk);
		repeat (per * (m[0] + 1) * pre) begin
			@(posedge core_clk);
			for (int k = 0; k < 6; k++) hi[k] += int'(pwm_out[k]);
		end
		for (int k = 0; k < 6; k++) check("pulse width", hi[k], per * pre * exp_hi(k + 1));
		$display("test widths done");
	endtask : measure
	task automatic give_verdict();
		$display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		check("watchdog", 32'h0, 32'h1);
		give_verdict();
	end
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		avs_req = '0;
		seed = 32'h17C2;
		dbl = 7'h14;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdc("ctrl", PWMT_OFS_CTRL, 32'h0);
		rdc("count", PWMT_OFS_COUNT, 32'h0);
		rdc("misaligned", 6'h02, 32'h0);
		check("flags", match_flags, 32'h0);
		repeat (4) begin
			nv = $random(seed);
			wr(PWMT_OFS_PRESCALE, nv);
			rdc("prescale", PWMT_OFS_PRESCALE, nv);
		end
		wr(PWMT_OFS_PRECOUNT, 32'hFFFF);
		rdc("precount", PWMT_OFS_PRECOUNT, 32'h0);
		// Timer mode: stop on match three, two cycles per count
		wr(PWMT_OFS_PRESCALE, 32'h1);
		wr(PWMT_OFS_MATCH0, 32'h14);
		wr(PWMT_OFS_MATCH0 + 6'h0C, 32'h7);
		wr(PWMT_OFS_MATCHCTL, 32'hA02);
		wr(PWMT_OFS_CTRL, 32'h1);
		repeat (40) @(posedge core_clk);
		rdc("stop count", PWMT_OFS_COUNT, 32'h7);
		rdc("stop run", PWMT_OFS_CTRL, 32'h0);
		check("stop flag", match_flags, 32'h8);
		check("timer pins", pwm_out, 32'h0);
		wr(PWMT_OFS_FLAGS, 32'h8);
		@(negedge core_clk);
		check("flag clear", match_flags, 32'h0);
		wr(PWMT_OFS_MATCH0, 32'h4);
		wr(PWMT_OFS_MATCHCTL, 32'h3);
		// Count stopped at 7, above the new period end, so restart from zero
		wr(PWMT_OFS_COUNT, 32'h0);
		wr(PWMT_OFS_CTRL, 32'h1);
		repeat (30) @(posedge core_clk);
		bus(1'b0, PWMT_OFS_COUNT, 32'h0);
		check("wrapped count", rd <= 32'h4, 32'h1);
		check("wrap flag", match_flags, 32'h1);
		$display("test timer done");
		// Modulation: two double-edge outputs of opposite polarity
		wr(PWMT_OFS_CTRL, 32'h0);
		wr(PWMT_OFS_PRESCALE, 32'h0);
		wr(PWMT_OFS_COUNT, 32'h0);
		wr(PWMT_OFS_FLAGS, 32'h7F);
		m = '{32'hB, 32'h3, 32'h8, 32'h9, 32'h2, 32'h0, 32'hB};
		for (int k = 0; k < 7; k++) wr(PWMT_OFS_MATCH0 + 6'(4 * k), m[k]);
		wr(PWMT_OFS_OUTCTL, 32'h7E14);
		wr(PWMT_OFS_RELEASE, 32'h7F);
		wr(PWMT_OFS_CTRL, 32'h9);
		measure(2, 1);
		nv = 1 + {$random(seed)} % 6;
		wr(PWMT_OFS_MATCH0 + 6'h04, nv);
		rdc("shadow", PWMT_OFS_MATCH0 + 6'h04, nv);
		measure(2, 1);
		wr(PWMT_OFS_RELEASE, 32'h2);
		m[1] = nv;
		measure(2, 1);
		wr(PWMT_OFS_PRESCALE, 32'h2);
		measure(2, 3);
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		check("pins after reset", pwm_out, 32'h0);
		rdc("ctrl after reset", PWMT_OFS_CTRL, 32'h0);
		$display("test reset done");
		give_verdict();
	end
endmodule : tb_pwm_match_timer
bind pwmt_top pwmt_props #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_pwmt_props (
	.CORE_CLK(CORE_CLK),
	.SYS_RST(SYS_RST),
	.AVS_REQ(AVS_REQ),
	.AVS_RSP(AVS_RSP),
	.PWM_OUT(PWM_OUT),
	.MATCH_FLAGS(MATCH_FLAGS)
);
